// file: hdl/iosd_map.svh
// constants for the low i/o space decoder
`ifndef IOSD_MAP_SVH
`define IOSD_MAP_SVH
`define IOSD_BANK_B_PIN_LEVEL      6'h03
`define IOSD_BANK_B_DIRECTION      6'h04
`define IOSD_BANK_B_DRIVE_LATCH    6'h05
`define IOSD_BANK_C_PIN_LEVEL      6'h06
`define IOSD_BANK_C_DIRECTION      6'h07
`define IOSD_BANK_C_DRIVE_LATCH    6'h08
`define IOSD_BANK_D_PIN_LEVEL      6'h09
`define IOSD_BANK_D_DIRECTION      6'h0a
`define IOSD_BANK_D_DRIVE_LATCH    6'h0b
`define IOSD_BANK_E_PIN_LEVEL      6'h0c
`define IOSD_BANK_E_DIRECTION      6'h0d
`define IOSD_BANK_E_DRIVE_LATCH    6'h0e
`define IOSD_TIMER8_EVENT_FLAGS    6'h15
`define IOSD_TIMER16_EVENT_FLAGS   6'h16
`define IOSD_SCRATCH_BYTE_1        6'h19
`define IOSD_SCRATCH_BYTE_2        6'h1a
`define IOSD_PIN_CHANGE_FLAGS      6'h1b
`define IOSD_BIT_OP_LAST           6'h1f
`define IOSD_IO_LAST               6'h3f
`define IOSD_DATA_OFFSET           8'h20
`define IOSD_DATA_IO_LAST          8'h5f
`define IOSD_EXT_FIRST             8'h60
`define IOSD_BANK_E_MASK           8'h07
`define IOSD_TIMER8_MASK           8'h07
`define IOSD_TIMER16_MASK          8'h27
`define IOSD_PIN_CHANGE_MASK       8'h0f
`define IOSD_RESET_BYTE            8'h00
`endif

// file: hdl/iosd_pkg.sv
// types for the low i/o space decoder
package iosd_pkg;
  // operation carried by the core on each access
  typedef enum logic [2:0] {
    IOSD_OP_NONE      = 3'h0,
    IOSD_OP_IN        = 3'h1,
    IOSD_OP_OUT       = 3'h2,
    IOSD_OP_SET_BIT   = 3'h3,
    IOSD_OP_CLEAR_BIT = 3'h4,
    IOSD_OP_SKIP_ONE  = 3'h5,
    IOSD_OP_SKIP_ZERO = 3'h6,
    IOSD_OP_DATA      = 3'h7
  } iosd_op_t;
endpackage : iosd_pkg

// file: hdl/iosd_bank_if.sv
// carrier between the decoder and one port bank
`timescale 1ns/1ps
interface iosd_bank_if;
  logic [7:0] dir;
  logic [7:0] latch;
  logic [7:0] level;
  modport ctrl (output dir, output latch, input level);
  modport bank (input dir, input latch, output level);
endinterface : iosd_bank_if

// file: hdl/iosd_port_bank.sv
// one parallel port bank: pin drive and synchronised pin level
`timescale 1ns/1ps
module iosd_port_bank #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  // decoder side
  iosd_bank_if.bank             bank_if,
  // pins
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe_n_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } iosd_bank_state_t;
  iosd_bank_state_t state_ff, nxt_state;
  always_comb begin
    nxt_state      = state_ff;
    nxt_state.meta = pin_in;
    nxt_state.sync = state_ff.meta;
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end
  assign pin_out       = bank_if.latch[WIDTH-1:0];
  assign pin_oe_n_out  = ~bank_if.dir[WIDTH-1:0];
  assign bank_if.level = 8'(state_ff.sync);
endmodule : iosd_port_bank

// file: hdl/iosd_io_space.sv
// low i/o space decoder with port banks, scratch bytes and event flags
//
// Function
// - set/clear one bit in 0x00-0x1f
// - skip tests on one bit in 0x00-0x1f
// - flags clear on written one only
// - bit ops never clear other flags
// - io view 0x00-0x3f, data view plus 0x20
// - 0x60-0xff reachable by data view only
`timescale 1ns/1ps
`include "iosd_map.svh"
module iosd_io_space (
  // clock and reset
  input  wire logic               clock_in,
  input  wire logic               rst_n_in,
  // core access
  input  iosd_pkg::iosd_op_t      op_in,
  input  wire logic [7:0]         addr_in,
  input  wire logic [7:0]         wdata_in,
  input  wire logic               data_we_in,
  input  wire logic [2:0]         bit_sel_in,
  output logic      [7:0]         rdata_out,
  output logic                    skip_out,
  // extended space, served elsewhere
  output logic                    ext_sel_out,
  output logic                    ext_we_out,
  output logic      [7:0]         ext_addr_out,
  output logic      [7:0]         ext_wdata_out,
  input  wire logic [7:0]         ext_rdata_in,
  // flag event sources, same clock
  input  wire logic [7:0]         timer8_event_in,
  input  wire logic [7:0]         timer16_event_in,
  input  wire logic [7:0]         pin_change_event_in,
  // pins
  input  wire logic [7:0]         bank_b_pin_in,
  output logic      [7:0]         bank_b_pin_out,
  output logic      [7:0]         bank_b_pin_oe_n_out,
  input  wire logic [7:0]         bank_c_pin_in,
  output logic      [7:0]         bank_c_pin_out,
  output logic      [7:0]         bank_c_pin_oe_n_out,
  input  wire logic [7:0]         bank_d_pin_in,
  output logic      [7:0]         bank_d_pin_out,
  output logic      [7:0]         bank_d_pin_oe_n_out,
  input  wire logic [2:0]         bank_e_pin_in,
  output logic      [2:0]         bank_e_pin_out,
  output logic      [2:0]         bank_e_pin_oe_n_out
);
  import iosd_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [3:0][7:0] dir;
    logic [3:0][7:0] latch;
    logic [7:0]      timer8_flags;
    logic [7:0]      timer16_flags;
    logic [7:0]      pin_change_flags;
    logic [7:0]      scratch1;
    logic [7:0]      scratch2;
    logic [7:0]      rdata;
    logic            skip;
  } iosd_state_t;

  iosd_state_t state_ff, nxt_state;
  logic [3:0][7:0] level;
  logic [7:0]      mask_e;

  // ****************************************
  // port banks
  // ****************************************
  // banks keep pins as inputs out of reset: direction clears to zero
  iosd_bank_if bank_b_if ();
  iosd_bank_if bank_c_if ();
  iosd_bank_if bank_d_if ();
  iosd_bank_if bank_e_if ();

  assign bank_b_if.dir   = state_ff.dir[0];
  assign bank_b_if.latch = state_ff.latch[0];
  assign bank_c_if.dir   = state_ff.dir[1];
  assign bank_c_if.latch = state_ff.latch[1];
  assign bank_d_if.dir   = state_ff.dir[2];
  assign bank_d_if.latch = state_ff.latch[2];
  assign bank_e_if.dir   = state_ff.dir[3];
  assign bank_e_if.latch = state_ff.latch[3];
  assign level[0] = bank_b_if.level;
  assign level[1] = bank_c_if.level;
  assign level[2] = bank_d_if.level;
  assign level[3] = bank_e_if.level;
  // bank e has three pins; its unused bits read and store as zero
  assign mask_e   = `IOSD_BANK_E_MASK;

  iosd_port_bank #(.WIDTH(8)) u_bank_b (
    .clock_in     (clock_in),
    .rst_n_in     (rst_n_in),
    .bank_if      (bank_b_if),
    .pin_in       (bank_b_pin_in),
    .pin_out      (bank_b_pin_out),
    .pin_oe_n_out (bank_b_pin_oe_n_out)
  );
  iosd_port_bank #(.WIDTH(8)) u_bank_c (
    .clock_in     (clock_in),
    .rst_n_in     (rst_n_in),
    .bank_if      (bank_c_if),
    .pin_in       (bank_c_pin_in),
    .pin_out      (bank_c_pin_out),
    .pin_oe_n_out (bank_c_pin_oe_n_out)
  );
  iosd_port_bank #(.WIDTH(8)) u_bank_d (
    .clock_in     (clock_in),
    .rst_n_in     (rst_n_in),
    .bank_if      (bank_d_if),
    .pin_in       (bank_d_pin_in),
    .pin_out      (bank_d_pin_out),
    .pin_oe_n_out (bank_d_pin_oe_n_out)
  );
  iosd_port_bank #(.WIDTH(3)) u_bank_e (
    .clock_in     (clock_in),
    .rst_n_in     (rst_n_in),
    .bank_if      (bank_e_if),
    .pin_in       (bank_e_pin_in),
    .pin_out      (bank_e_pin_out),
    .pin_oe_n_out (bank_e_pin_oe_n_out)
  );

  // ****************************************
  // address view
  // ****************************************
  logic       io_valid;
  logic [5:0] io_addr;
  logic       is_write;
  logic       is_read;
  logic       bit_op;
  logic [7:0] cur;
  logic [7:0] bit_mask;
  logic [7:0] wval;

  always_comb begin
    io_valid = 1'b0;
    io_addr  = 6'h00;
    is_write = 1'b0;
    is_read  = 1'b0;
    bit_op   = 1'b0;
    case (op_in)
      IOSD_OP_IN, IOSD_OP_OUT: begin
        io_valid = 1'b1;
        io_addr  = addr_in[5:0];
        is_write = (op_in == IOSD_OP_OUT);
        is_read  = (op_in == IOSD_OP_IN);
      end
      IOSD_OP_SET_BIT, IOSD_OP_CLEAR_BIT, IOSD_OP_SKIP_ONE, IOSD_OP_SKIP_ZERO: begin
        // only the low 32 addresses are bit addressable
        // upper address bits are ignored, so 0x20-0x3f alias onto the low half
        io_valid = 1'b1;
        io_addr  = {1'b0, addr_in[4:0]};
        bit_op   = 1'b1;
      end
      IOSD_OP_DATA: begin
        // data view: 0x20..0x5f maps onto the io space
        // lower data addresses belong to the working registers, not here
        if (addr_in >= `IOSD_DATA_OFFSET && addr_in <= `IOSD_DATA_IO_LAST) begin
          io_valid = 1'b1;
          io_addr  = 6'(addr_in - `IOSD_DATA_OFFSET);
          is_write = data_we_in;
          is_read  = !data_we_in;
        end
      end
      default: begin
        io_valid = 1'b0;
      end
    endcase
  end

  // extended space only through the data view
  assign ext_sel_out   = (op_in == IOSD_OP_DATA) && (addr_in >= `IOSD_EXT_FIRST);
  assign ext_we_out    = ext_sel_out && data_we_in;
  // ext_addr_out and ext_wdata_out follow the core on every op; only ext_sel_out and ext_we_out need the data op
  assign ext_addr_out  = addr_in;
  assign ext_wdata_out = wdata_in;

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    // holes and unmapped addresses read as zero
    cur = `IOSD_RESET_BYTE;
    case (io_addr)
      `IOSD_BANK_B_PIN_LEVEL:    cur = level[0];
      `IOSD_BANK_B_DIRECTION:    cur = state_ff.dir[0];
      `IOSD_BANK_B_DRIVE_LATCH:  cur = state_ff.latch[0];
      `IOSD_BANK_C_PIN_LEVEL:    cur = level[1];
      `IOSD_BANK_C_DIRECTION:    cur = state_ff.dir[1];
      `IOSD_BANK_C_DRIVE_LATCH:  cur = state_ff.latch[1];
      `IOSD_BANK_D_PIN_LEVEL:    cur = level[2];
      `IOSD_BANK_D_DIRECTION:    cur = state_ff.dir[2];
      `IOSD_BANK_D_DRIVE_LATCH:  cur = state_ff.latch[2];
      `IOSD_BANK_E_PIN_LEVEL:    cur = level[3] & mask_e;
      `IOSD_BANK_E_DIRECTION:    cur = state_ff.dir[3];
      `IOSD_BANK_E_DRIVE_LATCH:  cur = state_ff.latch[3];
      `IOSD_TIMER8_EVENT_FLAGS:  cur = state_ff.timer8_flags;
      `IOSD_TIMER16_EVENT_FLAGS: cur = state_ff.timer16_flags;
      `IOSD_SCRATCH_BYTE_1:      cur = state_ff.scratch1;
      `IOSD_SCRATCH_BYTE_2:      cur = state_ff.scratch2;
      `IOSD_PIN_CHANGE_FLAGS:    cur = state_ff.pin_change_flags;
      default:                   cur = `IOSD_RESET_BYTE;
    endcase
  end

  // ****************************************
  // write path
  // ****************************************
  always_comb begin
    // bit ops rewrite the current value, so untouched bits keep their state
    bit_mask = 8'h01 << bit_sel_in;
    wval     = wdata_in;
    if (op_in == IOSD_OP_SET_BIT) begin
      wval = cur | bit_mask;
    end else if (op_in == IOSD_OP_CLEAR_BIT) begin
      wval = cur & ~bit_mask;
    end
  end

  // pin-level registers take no write, bit ops included
  logic wr_en;
  logic [7:0] flag_clr;
  assign wr_en = io_valid && (is_write || op_in == IOSD_OP_SET_BIT ||
                              op_in == IOSD_OP_CLEAR_BIT);

  always_comb begin
    // flag writes: bit ops touch only the addressed bit, and only a set clears it
    if (op_in == IOSD_OP_SET_BIT) begin
      flag_clr = bit_mask;
    end else if (op_in == IOSD_OP_CLEAR_BIT) begin
      flag_clr = 8'h00;
    end else begin
      flag_clr = wdata_in;
    end
  end

  always_comb begin
    nxt_state       = state_ff;
    nxt_state.skip  = 1'b0;
    // read data holds until the next read, so the core may take it late
    nxt_state.rdata = state_ff.rdata;
    if (is_read && io_valid) begin
      nxt_state.rdata = cur;
    end else if (ext_sel_out && !data_we_in) begin
      nxt_state.rdata = ext_rdata_in;
    end
    // skip is a one-cycle pulse; the core must act on it at once
    if (io_valid && op_in == IOSD_OP_SKIP_ONE) begin
      nxt_state.skip = cur[bit_sel_in];
    end else if (io_valid && op_in == IOSD_OP_SKIP_ZERO) begin
      nxt_state.skip = !cur[bit_sel_in];
    end
    if (wr_en) begin
      case (io_addr)
        `IOSD_BANK_B_DIRECTION:    nxt_state.dir[0]   = wval;
        `IOSD_BANK_B_DRIVE_LATCH:  nxt_state.latch[0] = wval;
        `IOSD_BANK_C_DIRECTION:    nxt_state.dir[1]   = wval;
        `IOSD_BANK_C_DRIVE_LATCH:  nxt_state.latch[1] = wval;
        `IOSD_BANK_D_DIRECTION:    nxt_state.dir[2]   = wval;
        `IOSD_BANK_D_DRIVE_LATCH:  nxt_state.latch[2] = wval;
        `IOSD_BANK_E_DIRECTION:    nxt_state.dir[3]   = wval & mask_e;
        `IOSD_BANK_E_DRIVE_LATCH:  nxt_state.latch[3] = wval & mask_e;
        `IOSD_SCRATCH_BYTE_1:      nxt_state.scratch1 = wval;
        `IOSD_SCRATCH_BYTE_2:      nxt_state.scratch2 = wval;
        `IOSD_TIMER8_EVENT_FLAGS:
          nxt_state.timer8_flags = state_ff.timer8_flags & ~flag_clr;
        `IOSD_TIMER16_EVENT_FLAGS:
          nxt_state.timer16_flags = state_ff.timer16_flags & ~flag_clr;
        `IOSD_PIN_CHANGE_FLAGS:
          nxt_state.pin_change_flags = state_ff.pin_change_flags & ~flag_clr;
        default: begin
          // reserved and read-only addresses ignore writes
          nxt_state.skip = nxt_state.skip;
        end
      endcase
    end
    // a new event beats a clear in the same cycle
    nxt_state.timer8_flags = nxt_state.timer8_flags |
                             (timer8_event_in & `IOSD_TIMER8_MASK);
    nxt_state.timer16_flags = nxt_state.timer16_flags |
                              (timer16_event_in & `IOSD_TIMER16_MASK);
    nxt_state.pin_change_flags = nxt_state.pin_change_flags |
                                 (pin_change_event_in & `IOSD_PIN_CHANGE_MASK);
  end

  // reset leaves every bank as an input with its latch low
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rdata_out = state_ff.rdata;
  assign skip_out  = state_ff.skip;
endmodule : iosd_io_space

// file: verification/iosd_core_model.sv
// core-side model issuing one access per cycle
`timescale 1ns/1ps
`include "iosd_map.svh"
module iosd_core_model (
  // clock
  input  wire logic         clock_in,
  // access
  output iosd_pkg::iosd_op_t op_out,
  output logic [7:0]        addr_out,
  output logic [7:0]        wdata_out,
  output logic              we_out,
  output logic [2:0]        bit_out,
  input  wire logic [7:0]   rdata_in,
  input  wire logic         skip_in
);
  import iosd_pkg::*;
  initial begin
    op_out = IOSD_OP_NONE;
    {addr_out, wdata_out, we_out, bit_out} = '0;
  end
  // called just after an edge; the request stays up until the next call
  task automatic acc(input iosd_op_t o, input logic [7:0] a, input logic [7:0] d,
                     input logic w, input logic [2:0] b, output logic [7:0] rd,
                     output logic sk);
    if (o == IOSD_OP_OUT && a[5:0] == `IOSD_BANK_E_DRIVE_LATCH) d = d & `IOSD_BANK_E_MASK;
    if (o == IOSD_OP_OUT && a[5:0] < 6'h03) o = IOSD_OP_NONE;
    op_out = o;
    addr_out = a;
    wdata_out = d;
    we_out = w;
    bit_out = b;
    @(posedge clock_in);
    #1;
    rd = rdata_in;
    sk = skip_in;
  endtask : acc
endmodule : iosd_core_model

// file: verification/iosd_io_space_asserts.sv
// assertions on the low i/o space decoder ports
`timescale 1ns/1ps
module iosd_io_space_asserts (
  // clock and reset
  input wire logic          clock_in,
  input wire logic          rst_n_in,
  // core access
  input iosd_pkg::iosd_op_t op_in,
  input wire logic [7:0]    addr_in,
  input wire logic [7:0]    wdata_in,
  input wire logic          data_we_in,
  input wire logic [2:0]    bit_sel_in,
  input wire logic          skip_out,
  input wire logic [7:0]    rdata_out,
  // extended space and pins
  input wire logic          ext_sel_out,
  input wire logic          ext_we_out,
  input wire logic [7:0]    ext_addr_out,
  input wire logic [7:0]    bank_b_pin_out,
  input wire logic [7:0]    bank_b_pin_oe_n_out,
  input wire logic [7:0]    bank_d_pin_out
);
  import iosd_pkg::*;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_set_d;
    op_in == IOSD_OP_SET_BIT && addr_in[4:0] == 5'h0b;
  endsequence
  sequence s_clr_d;
    op_in == IOSD_OP_CLEAR_BIT && addr_in[4:0] == 5'h0b;
  endsequence
  chk_set_one_bit: assert property (s_set_d |=> bank_d_pin_out[$past(bit_sel_in)] &&
    ((bank_d_pin_out ^ $past(bank_d_pin_out)) & ~(8'h01 << $past(bit_sel_in))) == 8'h00)
    else $error("set bit changed wrong bits");
  chk_clear_one_bit: assert property (s_clr_d |=> !bank_d_pin_out[$past(bit_sel_in)] &&
    ((bank_d_pin_out ^ $past(bank_d_pin_out)) & ~(8'h01 << $past(bit_sel_in))) == 8'h00)
    else $error("clear bit changed wrong bits");
  chk_skip_when_one: assert property (op_in == IOSD_OP_SKIP_ONE && addr_in[4:0] == 5'h0b &&
    bank_d_pin_out[bit_sel_in] |=> skip_out) else $error("skip on one missed");
  chk_no_skip_zero: assert property (op_in == IOSD_OP_SKIP_ZERO && addr_in[4:0] == 5'h0b &&
    bank_d_pin_out[bit_sel_in] |=> !skip_out) else $error("skip on zero wrongly taken");
  chk_skip_has_cause: assert property (skip_out |->
    $past(op_in) inside {IOSD_OP_SKIP_ONE, IOSD_OP_SKIP_ZERO}) else $error("skip without test");
  chk_dir_sets_oe: assert property (op_in == IOSD_OP_OUT && addr_in[5:0] == 6'h04 |=>
    bank_b_pin_oe_n_out == ~$past(wdata_in)) else $error("direction not on enables");
  chk_data_view_store: assert property (op_in == IOSD_OP_DATA && data_we_in &&
    addr_in == 8'h25 |=> bank_b_pin_out == $past(wdata_in)) else $error("data view store lost");
  chk_ext_only_data: assert property (ext_sel_out |->
    op_in == IOSD_OP_DATA && addr_in >= 8'h60) else $error("ext selected outside data view");
  chk_ext_reached: assert property (op_in == IOSD_OP_DATA && addr_in >= 8'h60 |->
    ext_sel_out && ext_we_out == data_we_in && ext_addr_out == addr_in)
    else $error("ext access not passed out");
  chk_bank_e_narrow: assert property (op_in == IOSD_OP_IN && addr_in[5:0] == 6'h0c |=>
    rdata_out[7:3] == 5'h00) else $error("bank e level wider than its pins");
endmodule : iosd_io_space_asserts
bind iosd_io_space iosd_io_space_asserts iosd_io_space_asserts_inst (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .op_in(op_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .data_we_in(data_we_in), .bit_sel_in(bit_sel_in), .skip_out(skip_out),
  .ext_sel_out(ext_sel_out), .ext_we_out(ext_we_out), .ext_addr_out(ext_addr_out),
  .bank_b_pin_out(bank_b_pin_out), .bank_b_pin_oe_n_out(bank_b_pin_oe_n_out),
  .bank_d_pin_out(bank_d_pin_out), .rdata_out(rdata_out));

// file: verification/io_space_port_decode_test.sv
// self-checking bench for the low i/o space decoder
`timescale 1ns/1ps
module io_space_port_decode_test;
  import iosd_pkg::*;
  // ********
  // signals
  // ********
  logic       clock_in = 1'b0;
  logic       rst_n_in = 1'b0;
  iosd_op_t   op;
  logic [7:0] addr, wdata, rdata, ext_rdata, ev8, ev16, evpc, pb, pc, pd, b_out, b_oe_n, d_out;
  logic [7:0] got;
  logic [7:0] c_out, c_oe_n, d_oe_n, ext_a, ext_wd;
  logic [2:0] e_out, e_oe_n;
  logic       ext_s, ext_w;
  logic [2:0] bsel, pe;
  logic       we, skip, sk;
  int         num_errors = 0;
  int         n_tests = 0;
  int         cycles = 0;
  always #4 clock_in = ~clock_in;
  iosd_io_space iosd_io_space_inst (.clock_in(clock_in), .rst_n_in(rst_n_in), .op_in(op),
    .addr_in(addr), .wdata_in(wdata), .data_we_in(we), .bit_sel_in(bsel), .rdata_out(rdata),
    .skip_out(skip), .ext_sel_out(ext_s), .ext_we_out(ext_w), .ext_addr_out(ext_a),
    .ext_wdata_out(ext_wd),
    .ext_rdata_in(ext_rdata), .timer8_event_in(ev8), .timer16_event_in(ev16),
    .pin_change_event_in(evpc), .bank_b_pin_in(pb), .bank_b_pin_out(b_out),
    .bank_b_pin_oe_n_out(b_oe_n), .bank_c_pin_in(pc), .bank_c_pin_out(c_out),
    .bank_c_pin_oe_n_out(c_oe_n), .bank_d_pin_in(pd), .bank_d_pin_out(d_out),
    .bank_d_pin_oe_n_out(d_oe_n), .bank_e_pin_in(pe), .bank_e_pin_out(e_out),
    .bank_e_pin_oe_n_out(e_oe_n));
  iosd_core_model iosd_core_model_inst (.clock_in(clock_in), .op_out(op), .addr_out(addr),
    .wdata_out(wdata), .we_out(we), .bit_out(bsel), .rdata_in(rdata), .skip_in(skip));
  // ********
  // tasks
  // ********
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic acc(input iosd_op_t o, input logic [7:0] a, input logic [7:0] d,
                     input logic w, input logic [2:0] b);
    iosd_core_model_inst.acc(o, a, d, w, b, got, sk);
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(IOSD_OP_OUT, a, d, 1'b0, 3'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(IOSD_OP_IN, a, 8'h00, 1'b0, 3'h0);
    chk(got, e);
  endtask : rd
  task automatic dl(input logic [7:0] a, input logic [7:0] e);
    acc(IOSD_OP_DATA, a, 8'h00, 1'b0, 3'h0);
    chk(got, e);
  endtask : dl
  task automatic bt(input iosd_op_t o, input logic [7:0] a, input logic [2:0] b, input logic e);
    acc(o, a, 8'h00, 1'b0, b);
    if (o == IOSD_OP_SKIP_ONE || o == IOSD_OP_SKIP_ZERO) chk({7'h00, sk}, {7'h00, e});
  endtask : bt
  // hang guard; the sequence needs well under 300 cycles
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      summarize();
    end
  end
  // ********
  // sequence
  // ********
  initial begin
    {ext_rdata, ev8, ev16, evpc, pb, pc, pd, pe} = '0;
    repeat (8) @(posedge clock_in);
    #1 rst_n_in = 1'b1;
    chk(b_oe_n, 8'hff);
    chk(b_out, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(8'h04 + 8'(3 * i), 8'ha5 ^ 8'(i));
      acc(IOSD_OP_DATA, 8'h25 + 8'(3 * i), 8'h3c + 8'(i), 1'b1, 3'h0);
      dl(8'h24 + 8'(3 * i), 8'ha5 ^ 8'(i));
      rd(8'h05 + 8'(3 * i), 8'h3c + 8'(i));
    end
    chk(b_oe_n, 8'h5a);
    chk(b_out, 8'h3c);
    chk(c_oe_n, 8'h5b);
    chk(c_out, 8'h3d);
    chk(d_oe_n, 8'h58);
    wr(8'h1a, 8'h81);
    dl(8'h3a, 8'h81);
    wr(8'h0e, 8'hff);
    rd(8'h0e, 8'h07);
    chk({5'h00, e_out}, 8'h07);
    chk({5'h00, e_oe_n}, 8'h07);
    rd(8'h10, 8'h00);
    $display("test views done");
    bt(IOSD_OP_SET_BIT, 8'h0b, 3'h7, 1'b0);
    bt(IOSD_OP_CLEAR_BIT, 8'h0b, 3'h1, 1'b0);
    rd(8'h0b, 8'hbc);
    chk(d_out, 8'hbc);
    bt(IOSD_OP_SKIP_ONE, 8'h0b, 3'h7, 1'b1);
    bt(IOSD_OP_SKIP_ONE, 8'h0b, 3'h1, 1'b0);
    bt(IOSD_OP_SKIP_ZERO, 8'h0b, 3'h0, 1'b1);
    bt(IOSD_OP_SKIP_ZERO, 8'h0b, 3'h2, 1'b0);
    $display("test bit ops done");
    {ev8, ev16, evpc} = {3{8'hff}};
    acc(IOSD_OP_NONE, 8'h00, 8'h00, 1'b0, 3'h0);
    {ev8, ev16, evpc} = '0;
    rd(8'h15, 8'h07);
    rd(8'h1b, 8'h0f);
    wr(8'h16, 8'h01);
    rd(8'h16, 8'h26);
    wr(8'h16, 8'h00);
    rd(8'h16, 8'h26);
    bt(IOSD_OP_SET_BIT, 8'h16, 3'h2, 1'b0);
    bt(IOSD_OP_CLEAR_BIT, 8'h16, 3'h5, 1'b0);
    rd(8'h16, 8'h22);
    ev16 = 8'h01;
    wr(8'h16, 8'h01);
    ev16 = 8'h00;
    rd(8'h16, 8'h23);
    bt(IOSD_OP_SKIP_ONE, 8'h15, 3'h0, 1'b1);
    $display("test flags done");
    ext_rdata = 8'h5a;
    dl(8'h80, 8'h5a);
    acc(IOSD_OP_DATA, 8'h60, 8'h11, 1'b1, 3'h0);
    chk(ext_wd, 8'h11);
    chk(ext_a, 8'h60);
    chk({6'h00, ext_s, ext_w}, 8'h03);
    rd(8'h3f, 8'h00);
    chk({7'h00, ext_s}, 8'h00);
    pc = 8'h96;
    pe = 3'h5;
    repeat (3) acc(IOSD_OP_NONE, 8'h00, 8'h00, 1'b0, 3'h0);
    rd(8'h06, 8'h96);
    rd(8'h0c, 8'h05);
    $display("test ext and pins done");
    acc(IOSD_OP_NONE, 8'h00, 8'h00, 1'b0, 3'h0);
    summarize();
  end
endmodule : io_space_port_decode_test
